/* File: rtl/cevu_cfg.svh */
// constants for the exception vector unit
// How it works
// - untaken path never runs after taken branch
// - taken branch two cycles, untaken one
// - exceptions resume at faulting instruction
// - traps resume at following instruction
// - listed event factors accepted except instruction and operand break
// - return op restores interrupted program
// - levels are five bits, smaller wins
// - fixed levels for emulator trap, trace, nmi
// - software write cannot drop mask at 16+ below 16
// - level 31 disables, mask 16 blocks user levels 16..30
// - undefined, coprocessor, soft trap ignore masks
// - request refused when level >= mask
// - pc at stack pointer, status at +4
// - vector table is 1KB at base
// - vector address is base+3FC-4*number
// - low two address bits forced zero
// - reset table default, fixed reset vector
// - fixed vector numbers for special factors
// - sources 0..47 to vectors 16..63
// - smallest level, then lowest number wins
// - maskable needs enable flag, nmi not
`ifndef CEVU_CFG_SVH
`define CEVU_CFG_SVH
`define CEVU_NSRC 48
`define CEVU_LVL_TRAP 5'h04
`define CEVU_LVL_NMI 5'h0F
`define CEVU_LVL_USER 5'h10
`define CEVU_LVL_OFF 5'h1F
`define CEVU_VEC_TOP 32'h000003FC
`define CEVU_TBR_RST 32'h000FFC00
`define CEVU_RST_VEC 32'h000FFFFC
`define CEVU_VN_COPABS 8'h07
`define CEVU_VN_COPERR 8'h08
`define CEVU_VN_EMU 8'h09
`define CEVU_VN_IBRK 8'h0A
`define CEVU_VN_OBRK 8'h0B
`define CEVU_VN_STEP 8'h0C
`define CEVU_VN_UNDEF 8'h0E
`define CEVU_VN_NMI 8'h0F
`define CEVU_VN_SRC0 8'h10
`define CEVU_VN_TRAPMIN 8'h42
`define CEVU_SAVE_OFS 32'h00000004
`define CEVU_RET_ADV 32'h00000008
`define CEVU_FLAG_I 4
`define CEVU_FLAG_S 5
`define CEVU_FLAG_T 8
`define CEVU_ILM_LSB 16
`define CEVU_IN_BRA 32'h00000001
`endif

/* File: rtl/cevu_pkg.sv */
// types of the exception vector unit
package cevu_pkg;
  typedef enum logic [5:0] {
    CEVU_IDLE = 6'h01,
    CEVU_BRA2 = 6'h02,
    CEVU_PUSH = 6'h04,
    CEVU_VECT = 6'h08,
    CEVU_POPA = 6'h10,
    CEVU_POPB = 6'h20
  } cevu_state_type;
  typedef enum logic [3:0] {
    CEVU_K_NONE = 4'h0,
    CEVU_K_RESET = 4'h1,
    CEVU_K_UNDEF = 4'h2,
    CEVU_K_TRAP = 4'h3,
    CEVU_K_COPA = 4'h4,
    CEVU_K_COPE = 4'h5,
    CEVU_K_USER = 4'h6,
    CEVU_K_NMI = 4'h7,
    CEVU_K_EMU = 4'h8,
    CEVU_K_STEP = 4'h9,
    CEVU_K_DLY = 4'hA
  } cevu_kind_type;
endpackage

/* File: rtl/cevu_level_file.sv */
// per-source interrupt level memory with registered read-out
`timescale 1ns/1ns
`default_nettype none
`include "cevu_cfg.svh"
module cevu_level_file (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wrEn,
  input wire logic [5:0] wrIdx,
  input wire logic [4:0] wrLevel,
  input wire logic [5:0] rdIdx,
  output logic [4:0] rdLevel,
  output logic [239:0] allLevels
);
  logic [4:0] lvl [0:47]; // one level per source
  genvar g;
  // each entry resets to disabled so nothing fires before software sets it
  generate
    for (g = 0; g < 48; g = g + 1) begin : gEnt
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          lvl[g] <= `CEVU_LVL_OFF;
        end else if (wrEn && wrIdx == 6'(g)) begin
          lvl[g] <= wrLevel;
        end
      end
      assign allLevels[g*5 +: 5] = lvl[g];
    end
  endgenerate
  // registered read port, out-of-range index reads disabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdLevel <= `CEVU_LVL_OFF;
    end else begin
      rdLevel <= (rdIdx < 6'h30) ? lvl[rdIdx] : `CEVU_LVL_OFF;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/cevu_top.sv */
// exception, interrupt and trap sequencer with branch timing
`timescale 1ns/1ns
`default_nettype none
`include "cevu_cfg.svh"
module cevu_top (
  input wire logic clk,
  input wire logic arst_n,
  // pipeline side, one instruction offered per cycle
  input wire logic instValid,
  input wire logic [31:0] instPc,
  input wire logic [31:0] nextPc,
  input wire logic isBranch,
  input wire logic branchTaken,
  input wire logic [31:0] branchTarget,
  input wire logic isUndefined,
  input wire logic isSoftTrap,
  input wire logic [7:0] softTrapNum,
  input wire logic isEmuTrap,
  input wire logic isReturnOp,
  input wire logic coprocAbsent,
  input wire logic coprocError,
  input wire logic delayedIrq,
  input wire logic instBreak,
  input wire logic operandBreak,
  // peripheral requests
  input wire logic [47:0] srcRequest,
  input wire logic userNmi,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // memory port for stack frames and vector fetch
  output logic memReq,
  output logic memWrite,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  input wire logic [31:0] memRdata,
  // pipeline steering
  output logic instAccept,
  output logic flushNext,
  output logic pcLoad,
  output logic [31:0] pcValue,
  output logic [31:0] programStatusWord,
  output logic [31:0] systemStackPointer,
  output logic [31:0] tableBaseRegister
);
  // register offsets
  localparam logic [7:0] OFS_PSW = 8'h00;
  localparam logic [7:0] OFS_SSP = 8'h04;
  localparam logic [7:0] OFS_TBR = 8'h08;
  localparam logic [7:0] OFS_LVL = 8'h0C;
  localparam logic [7:0] OFS_LAST = 8'h10;

  cevu_pkg::cevu_state_type state; // sequencer state
  cevu_pkg::cevu_state_type next_state;
  logic [31:0] savePc; // restart address for the frame
  logic [31:0] saveOfs; // vector offset latched at entry
  logic [4:0] newIlm; // mask value applied at entry
  logic keepIlm; // entry leaves mask as is
  logic clrI; // entry clears enable flag
  logic [7:0] lastVec; // last accepted vector number
  logic resetPending; // reset vector still to fetch
  logic vecWait; // vector word stands on memRdata, pc loads now
  logic [5:0] lvlIdx; // level file write index from regWdata
  logic [4:0] lvlRead;
  logic [239:0] allLevels;

  // split of the status word
  wire [4:0] interrupt_level_mask = programStatusWord[`CEVU_ILM_LSB +: 5];
  wire iFlag = programStatusWord[`CEVU_FLAG_I];
  wire tFlag = programStatusWord[`CEVU_FLAG_T];

  // register decode
  wire wrPsw = regWr && regAddr == OFS_PSW;
  wire wrSsp = regWr && regAddr == OFS_SSP;
  wire wrTbr = regWr && regAddr == OFS_TBR;
  wire wrLvl = regWr && regAddr == OFS_LVL;
  wire [4:0] wrIlmRaw = regWdata[`CEVU_ILM_LSB +: 5];
  // once in user band the program can never climb into system levels
  wire [4:0] wrIlmCut = (interrupt_level_mask[4] && !wrIlmRaw[4]) ? (wrIlmRaw | `CEVU_LVL_USER) : wrIlmRaw;

  // priority search: smallest level, then lowest source number
  logic [4:0] bestLvl;
  logic [5:0] bestSrc;
  always_comb begin
    bestLvl = `CEVU_LVL_OFF;
    bestSrc = 6'h00;
    for (int k = `CEVU_NSRC - 1; k >= 0; k--) begin
      // non-strict compare scanning downward lets the lowest number win ties
      if (srcRequest[k] && allLevels[k*5 +: 5] <= bestLvl && allLevels[k*5 +: 5] != `CEVU_LVL_OFF) begin
        bestLvl = allLevels[k*5 +: 5];
        bestSrc = 6'(k);
      end
    end
  end
  wire userHit = bestLvl != `CEVU_LVL_OFF;
  wire userOk = userHit && (bestLvl < interrupt_level_mask) && iFlag && !tFlag;
  wire nmiOk = userNmi && (`CEVU_LVL_NMI < interrupt_level_mask) && !tFlag;
  wire emuOk = isEmuTrap && !tFlag;

  // event selection in acceptance order
  cevu_pkg::cevu_kind_type kind;
  always_comb begin
    if (!instValid) begin
      kind = cevu_pkg::CEVU_K_NONE;
    end else if (isUndefined) begin
      kind = cevu_pkg::CEVU_K_UNDEF;
    end else if (isSoftTrap) begin
      kind = cevu_pkg::CEVU_K_TRAP;
    end else if (coprocAbsent) begin
      kind = cevu_pkg::CEVU_K_COPA;
    end else if (coprocError) begin
      kind = cevu_pkg::CEVU_K_COPE;
    end else if (userOk) begin
      kind = cevu_pkg::CEVU_K_USER;
    end else if (nmiOk) begin
      kind = cevu_pkg::CEVU_K_NMI;
    end else if (delayedIrq && iFlag && !tFlag) begin
      kind = cevu_pkg::CEVU_K_DLY;
    end else if (emuOk) begin
      kind = cevu_pkg::CEVU_K_EMU;
    end else if (tFlag) begin
      kind = cevu_pkg::CEVU_K_STEP;
    end else begin
      kind = cevu_pkg::CEVU_K_NONE;
    end
  end

  // vector number for the chosen event
  logic [7:0] vecNum;
  always_comb begin
    case (kind)
      cevu_pkg::CEVU_K_UNDEF: vecNum = `CEVU_VN_UNDEF;
      cevu_pkg::CEVU_K_TRAP: vecNum = softTrapNum;
      cevu_pkg::CEVU_K_COPA: vecNum = `CEVU_VN_COPABS;
      cevu_pkg::CEVU_K_COPE: vecNum = `CEVU_VN_COPERR;
      cevu_pkg::CEVU_K_USER: vecNum = `CEVU_VN_SRC0 + {2'h0, bestSrc};
      cevu_pkg::CEVU_K_NMI: vecNum = `CEVU_VN_NMI;
      cevu_pkg::CEVU_K_DLY: vecNum = `CEVU_VN_SRC0 + 8'h2F;
      cevu_pkg::CEVU_K_EMU: vecNum = `CEVU_VN_EMU;
      cevu_pkg::CEVU_K_STEP: vecNum = `CEVU_VN_STEP;
      default: vecNum = 8'h00;
    endcase
  end
  wire [31:0] vecOfs = `CEVU_VEC_TOP - {22'h0, vecNum, 2'h0};
  // exceptions and interrupts restart the offered instruction, which never retired;
  // traps go on after the instruction that raised them
  wire isException = kind == cevu_pkg::CEVU_K_UNDEF || kind == cevu_pkg::CEVU_K_USER
    || kind == cevu_pkg::CEVU_K_NMI || kind == cevu_pkg::CEVU_K_DLY || kind == cevu_pkg::CEVU_K_STEP;
  wire [31:0] restartPc = isException ? instPc : nextPc;
  wire takeEvent = kind != cevu_pkg::CEVU_K_NONE;
  wire [31:0] vecAddrRaw = tableBaseRegister + saveOfs;
  wire [31:0] vecAddr = {vecAddrRaw[31:2], 2'h0};
  wire [31:0] pushSp = systemStackPointer - `CEVU_RET_ADV;

  // mask effect of each accepted event
  always_comb begin
    keepIlm = 1'b1;
    clrI = 1'b0;
    newIlm = interrupt_level_mask;
    case (kind)
      cevu_pkg::CEVU_K_USER: begin
        keepIlm = 1'b0;
        newIlm = bestLvl;
      end
      cevu_pkg::CEVU_K_NMI: begin
        keepIlm = 1'b0;
        newIlm = `CEVU_LVL_NMI;
      end
      cevu_pkg::CEVU_K_EMU, cevu_pkg::CEVU_K_STEP: begin
        keepIlm = 1'b0;
        newIlm = `CEVU_LVL_TRAP;
      end
      cevu_pkg::CEVU_K_TRAP: clrI = 1'b1;
      default: keepIlm = 1'b1;
    endcase
  end

  // sequencer transitions
  always_comb begin
    case (state)
      cevu_pkg::CEVU_IDLE: begin
        if (vecWait) begin
          next_state = cevu_pkg::CEVU_IDLE;
        end else if (resetPending) begin
          next_state = cevu_pkg::CEVU_VECT;
        end else if (takeEvent) begin
          next_state = cevu_pkg::CEVU_PUSH;
        end else if (instValid && isReturnOp) begin
          next_state = cevu_pkg::CEVU_POPA;
        end else if (instValid && isBranch && branchTaken) begin
          next_state = cevu_pkg::CEVU_BRA2;
        end else begin
          next_state = cevu_pkg::CEVU_IDLE;
        end
      end
      cevu_pkg::CEVU_BRA2: next_state = cevu_pkg::CEVU_IDLE;
      cevu_pkg::CEVU_PUSH: next_state = cevu_pkg::CEVU_VECT;
      cevu_pkg::CEVU_VECT: next_state = cevu_pkg::CEVU_IDLE;
      cevu_pkg::CEVU_POPA: next_state = cevu_pkg::CEVU_POPB;
      cevu_pkg::CEVU_POPB: next_state = cevu_pkg::CEVU_IDLE;
      default: next_state = cevu_pkg::CEVU_IDLE;
    endcase
  end

  // handshakes toward the pipeline
  // redirect cycle after a vector read takes no new instruction
  wire inIdle = state == cevu_pkg::CEVU_IDLE && !vecWait;
  assign instAccept = inIdle && !resetPending && instValid && !takeEvent;
  // the slot after a taken branch is squashed for its second cycle
  assign flushNext = state == cevu_pkg::CEVU_BRA2;

  // memory port: push writes status then pc, vector and pop read
  always_comb begin
    memReq = 1'b0;
    memWrite = 1'b0;
    memAddr = 32'h00000000;
    memWdata = 32'h00000000;
    case (state)
      cevu_pkg::CEVU_IDLE: begin
        if (inIdle && !resetPending && takeEvent) begin
          memReq = 1'b1;
          memWrite = 1'b1;
          memAddr = pushSp + `CEVU_SAVE_OFS;
          memWdata = programStatusWord;
        end else if (inIdle && !resetPending && instValid && isReturnOp) begin
          memReq = 1'b1;
          memAddr = systemStackPointer;
        end
      end
      cevu_pkg::CEVU_PUSH: begin
        memReq = 1'b1;
        memWrite = 1'b1;
        memAddr = systemStackPointer;
        memWdata = savePc;
      end
      cevu_pkg::CEVU_VECT: begin
        memReq = 1'b1;
        memAddr = resetPending ? `CEVU_RST_VEC : vecAddr;
      end
      cevu_pkg::CEVU_POPA: begin
        memReq = 1'b1;
        memAddr = systemStackPointer + `CEVU_SAVE_OFS;
      end
      default: memReq = 1'b0;
    endcase
  end
  // pc redirect uses read data one cycle after the vector read and the first pop read; taken branches load branchTarget
  assign pcLoad = vecWait || (state == cevu_pkg::CEVU_POPA)
    || (inIdle && instValid && isBranch && branchTaken && !takeEvent && !resetPending);
  assign pcValue = inIdle ? branchTarget : memRdata;

  // state and entry bookkeeping
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= cevu_pkg::CEVU_IDLE;
      resetPending <= 1'b1;
      vecWait <= 1'b0;
      savePc <= 32'h00000000;
      saveOfs <= 32'h00000000;
      lastVec <= 8'h00;
    end else begin
      state <= next_state;
      vecWait <= state == cevu_pkg::CEVU_VECT;
      if (state == cevu_pkg::CEVU_VECT) begin
        resetPending <= 1'b0;
      end
      if (inIdle && takeEvent && !resetPending) begin
        savePc <= restartPc;
        saveOfs <= vecOfs;
        lastVec <= vecNum;
      end
    end
  end

  // stack pointer: minus eight at entry, plus eight at return
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      systemStackPointer <= 32'h00000000;
    end else if (inIdle && takeEvent && !resetPending) begin
      systemStackPointer <= pushSp;
    end else if (state == cevu_pkg::CEVU_POPB) begin
      systemStackPointer <= systemStackPointer + `CEVU_RET_ADV;
    end else if (wrSsp) begin
      systemStackPointer <= regWdata;
    end
  end

  // status word: entry masking, pop restore, software write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      programStatusWord <= {11'h000, `CEVU_LVL_OFF, 16'h0000};
    end else if (inIdle && takeEvent && !resetPending) begin
      if (!keepIlm) begin
        programStatusWord[`CEVU_ILM_LSB +: 5] <= newIlm;
      end
      if (clrI) begin
        programStatusWord[`CEVU_FLAG_I] <= 1'b0;
      end
      programStatusWord[`CEVU_FLAG_S] <= 1'b0;
    end else if (state == cevu_pkg::CEVU_POPB) begin
      programStatusWord <= memRdata;
    end else if (wrPsw) begin
      programStatusWord <= {regWdata[31:21], wrIlmCut, regWdata[15:0]};
    end
  end

  // table base, default area after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tableBaseRegister <= `CEVU_TBR_RST;
    end else if (wrTbr) begin
      tableBaseRegister <= {regWdata[31:2], 2'h0};
    end
  end

  // level file write: index in bits 13:8, level in bits 4:0
  assign lvlIdx = regWdata[13:8];
  cevu_level_file uLevels (
    .clk(clk),
    .arst_n(arst_n),
    .wrEn(wrLvl),
    .wrIdx(lvlIdx),
    .wrLevel(regWdata[4:0]),
    .rdIdx(regAddr[7:2] - 6'h10),
    .rdLevel(lvlRead),
    .allLevels(allLevels)
  );

  // read data one cycle after the strobe
  logic [7:0] rdAddrQ;
  logic rdQ;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdAddrQ <= 8'h00;
      rdQ <= 1'b0;
    end else begin
      rdAddrQ <= regAddr;
      rdQ <= regRd;
    end
  end
  // level entries sit at 40..FC, one word each; unmapped reads zero
  always_comb begin
    if (!rdQ) begin
      regRdata = 32'h00000000;
    end else if (rdAddrQ >= 8'h40) begin
      regRdata = {27'h0, lvlRead};
    end else begin
      case (rdAddrQ)
        OFS_PSW: regRdata = programStatusWord;
        OFS_SSP: regRdata = systemStackPointer;
        OFS_TBR: regRdata = tableBaseRegister;
        OFS_LAST: regRdata = {24'h0, lastVec};
        default: regRdata = 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: tb/cevu_checker_sva.sv */
// port assertions for the exception unit
`timescale 1ns/1ns
`default_nettype none
module cevu_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instValid,
  input wire logic isBranch,
  input wire logic branchTaken,
  input wire logic [31:0] branchTarget,
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic instAccept,
  input wire logic flushNext,
  input wire logic pcLoad,
  input wire logic [31:0] pcValue,
  input wire logic [31:0] programStatusWord,
  input wire logic [31:0] tableBaseRegister
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // reads and pushes told apart by direction
  wire logic rdReq = memReq && !memWrite;
  wire logic wrReq = memReq && memWrite;
  property p_rst_vec;
    $rose(arst_n) |-> ##[0:3] (rdReq && memAddr == 32'h000FFFFC);
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector not fetched");
  property p_align;
    rdReq |-> memAddr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("read address not aligned");
  property p_stack;
    wrReq ##1 wrReq |-> memAddr == $past(memAddr) - 32'h4;
  endproperty
  a_stack: assert property (p_stack) else $error("second push not one word below");
  // low base bits are dropped, so compare against the aligned base
  property p_table;
    wrReq ##1 wrReq |=> rdReq && (memAddr - (tableBaseRegister & 32'hFFFFFFFC)) <= 32'h3FC;
  endproperty
  a_table: assert property (p_table) else $error("vector read outside table");
  property p_taken;
    instValid && isBranch && branchTaken && instAccept |->
      pcLoad && pcValue == branchTarget ##1 flushNext && !instAccept;
  endproperty
  a_taken: assert property (p_taken) else $error("taken branch timing wrong");
  property p_untaken;
    instValid && isBranch && !branchTaken && instAccept |-> !pcLoad ##1 !flushNext;
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken branch not single cycle");
  property p_floor;
    regWr && regAddr == 8'h00 && programStatusWord[20] |=> programStatusWord[20];
  endproperty
  a_floor: assert property (p_floor) else $error("level mask dropped below 16");
  // decision cycle is sampled two edges before the vector read
  property p_nmi_mask;
    rdReq && $past(wrReq) && memAddr == ((tableBaseRegister + 32'h3C0) & 32'hFFFFFFFC) |->
      $past(programStatusWord[20:16], 2) > 5'h0F;
  endproperty
  a_nmi_mask: assert property (p_nmi_mask) else $error("masked request taken");
endmodule
`default_nettype wire

/* File: tb/cevu_mem_model.sv */
// stack and vector memory beyond the memory port
`timescale 1ns/1ns
`default_nettype none
module cevu_mem_model (
  input wire logic clk,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic [31:0] memRdata
);
  logic [31:0] store [logic [31:0]]; // sparse words
  initial memRdata = 32'h0;
  // read data stands one cycle, else the bus shows the inverse
  always @(posedge clk) begin
    if (memReq && memWrite) begin
      store[memAddr] = memWdata;
      memRdata <= ~memRdata;
    end else if (memReq) begin
      memRdata <= store.exists(memAddr) ? store[memAddr] : ~memAddr;
    end else begin
      memRdata <= ~memRdata;
    end
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the exception unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'h0, arst_n = 1'h0, instValid = 1'h0, isBranch = 1'h0, branchTaken = 1'h0;
  logic isUndefined = 1'h0, isSoftTrap = 1'h0, isEmuTrap = 1'h0, isReturnOp = 1'h0;
  logic coprocAbsent = 1'h0, coprocError = 1'h0, delayedIrq = 1'h0, userNmi = 1'h0;
  logic instBreak = 1'h0, operandBreak = 1'h0, regWr = 1'h0, regRd = 1'h0;
  logic [31:0] instPc = '0, nextPc = '0, branchTarget = '0, regWdata = '0;
  logic [7:0] softTrapNum = '0, regAddr = '0, tv[3];
  logic [47:0] srcRequest = '0;
  logic [31:0] regRdata, memAddr, memWdata, memRdata, pcValue;
  logic [31:0] programStatusWord, systemStackPointer, tableBaseRegister;
  logic memReq, memWrite, instAccept, flushNext, pcLoad, sawLoad;
  logic [31:0] wa[$], wd[$], ra[$], rp[4];
  logic [31:0] mPsw, mSsp, mTbr, q, got, ldPc, pcI, pcN, tgt, retPsw, retPc;
  int failures = 0, tests_run = 0, i, w, sa[3], sb[3], la[3], lb[3], rl[4];
  always #5 clk = ~clk;
  cevu_top i_cevu_top (.clk, .arst_n, .instValid, .instPc, .nextPc, .isBranch, .branchTaken,
    .branchTarget, .isUndefined, .isSoftTrap, .softTrapNum, .isEmuTrap, .isReturnOp,
    .coprocAbsent, .coprocError, .delayedIrq, .instBreak, .operandBreak, .srcRequest, .userNmi,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .memReq, .memWrite, .memAddr, .memWdata,
    .memRdata, .instAccept, .flushNext, .pcLoad, .pcValue, .programStatusWord,
    .systemStackPointer, .tableBaseRegister);
  cevu_mem_model i_mem (.clk, .memReq, .memWrite, .memAddr, .memWdata, .memRdata);
  // memory traffic log, sampled before the edge updates land
  always @(posedge clk) begin
    if (memReq && memWrite) begin
      wa.push_back(memAddr);
      wd.push_back(memWdata);
    end else if (memReq) begin
      ra.push_back(memAddr);
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    @(negedge clk);
    r = regRdata;
  endtask
  task automatic lvl(input int s, input int l);
    wr(8'h0C, {18'h0, s[5:0], 3'h0, l[4:0]});
  endtask
  // k: 0 plain, 1 taken, 2 untaken, 3 undefined, 4 soft trap, 5 emulator,
  // 6 return, 7 coprocessor absent, 8 coprocessor error
  task automatic inst(input int k, input logic [7:0] n);
    int c;
    wa.delete();
    wd.delete();
    ra.delete();
    sawLoad = 1'h0;
    pcI = $urandom & 32'h0FFFFFFE;
    pcN = pcI + 32'h2;
    tgt = ~pcI & 32'h0FFFFFFE;
    @(posedge clk);
    instPc <= pcI;
    nextPc <= pcN;
    branchTarget <= tgt;
    isBranch <= k == 1 || k == 2;
    branchTaken <= k == 1;
    isUndefined <= k == 3;
    isSoftTrap <= k == 4;
    softTrapNum <= n;
    isEmuTrap <= k == 5;
    isReturnOp <= k == 6;
    coprocAbsent <= k == 7;
    coprocError <= k == 8;
    instValid <= 1'h1;
    // pipeline holds until the unit retires it or loads a pc
    for (c = 0; c < 20; c++) begin
      @(negedge clk);
      if (pcLoad === 1'h1) begin
        sawLoad = 1'h1;
        ldPc = pcValue;
      end
      if (instAccept === 1'h1 || pcLoad === 1'h1) break;
    end
    if (c == 20) begin
      failures++;
      final_report();
    end
    @(posedge clk);
    instValid <= 1'h0;
    @(negedge clk);
    got = {31'h0, flushNext};
    // a return loads its pc in the cycle after it retires
    if (pcLoad === 1'h1) begin
      sawLoad = 1'h1;
      ldPc = pcValue;
    end
  endtask
  // frame, vector fetch and status after one event; l < 0 keeps the mask
  task automatic ev(input logic [7:0] v, input logic pcOn, input logic [31:0] p,
                    input int l, input logic iClr);
    logic [31:0] va; // expected vector address
    while (wa.size() < 2) wa.push_back('x);
    while (wd.size() < 2) wd.push_back('x);
    while (ra.size() < 1) ra.push_back('x);
    chk("psw push addr", wa[0], mSsp - 32'h4);
    chk("psw push", wd[0], mPsw);
    chk("pc push addr", wa[1], mSsp - 32'h8);
    if (pcOn) chk("pc push", wd[1], p);
    va = (mTbr + 32'h3FC - {22'h0, v, 2'h0}) & 32'hFFFFFFFC;
    chk("vector addr", ra[0], va);
    chk("handler pc", ldPc, ~va);
    mSsp = mSsp - 32'h8;
    rd(8'h04, q);
    chk("stack ptr", q, mSsp);
    if (l >= 0) mPsw[20:16] = l[4:0];
    if (iClr) mPsw[4] = 1'h0;
    rd(8'h00, q);
    chk("status", q, mPsw);
  endtask
  initial begin
    void'($urandom(24456));
    repeat (8) @(posedge clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge clk);
    rd(8'h00, q);
    chk("psw reset", q, 32'h001F0000);
    rd(8'h08, q);
    chk("base reset", q, 32'h000FFC00);
    rd(8'h3C, q);
    chk("unmapped", q, 32'h0);
    mSsp = 32'h00008000;
    wr(8'h04, mSsp);
    mTbr = $urandom & 32'h0FFFFFFF; // low bits left random on purpose
    wr(8'h08, mTbr);
    mPsw = 32'h001F0010;
    wr(8'h00, 32'h00050010);
    rd(8'h00, q);
    chk("mask floor", q, 32'h00150010);
    wr(8'h00, mPsw);
    $display("registers done");
    inst(1, 8'h00);
    chk("taken target", ldPc, tgt);
    chk("taken flush", got, 32'h1);
    inst(2, 8'h00);
    chk("untaken load", {31'h0, sawLoad}, 32'h0);
    chk("untaken flush", got, 32'h0);
    $display("branches done");
    tv[0] = 8'h42;
    tv[1] = 8'hFF;
    tv[2] = 8'(66 + $urandom_range(189));
    for (i = 0; i < 3; i++) begin
      retPsw = mPsw;
      inst(4, tv[i]);
      retPc = pcN;
      ev(tv[i], 1'h1, pcN, -1, 1'h1);
    end
    inst(6, 8'h00);
    chk("return pc", ldPc, retPc);
    mSsp = mSsp + 32'h8;
    mPsw = retPsw;
    rd(8'h00, q);
    chk("return psw", q, mPsw);
    rd(8'h04, q);
    chk("return sp", q, mSsp);
    $display("traps and return done");
    mPsw = 32'h00100000;
    wr(8'h00, mPsw);
    inst(3, 8'h00);
    ev(8'h0E, 1'h1, pcI, -1, 1'h0);
    inst(5, 8'h00);
    ev(8'h09, 1'h1, pcN, 4, 1'h0);
    inst(7, 8'h00);
    ev(8'h07, 1'h1, pcN, -1, 1'h0);
    inst(8, 8'h00);
    ev(8'h08, 1'h1, pcN, -1, 1'h0);
    $display("exceptions done");
    sa = '{0, 3, 0};
    sb = '{47, 47, 0};
    la = '{20, 25, 30};
    lb = '{20, 17, 30};
    sa[2] = $urandom_range(20, 1);
    sb[2] = sa[2] + $urandom_range(26, 1);
    for (i = 0; i < 3; i++) begin
      lvl(sa[i], la[i]);
      lvl(sb[i], lb[i]);
      rd(8'(64 + 4 * sb[i]), q);
      chk("level readback", q, 32'(lb[i]));
      mPsw = 32'h001F0010;
      wr(8'h00, mPsw);
      srcRequest <= (48'h1 << sa[i]) | (48'h1 << sb[i]);
      inst(0, 8'h00);
      w = lb[i] < la[i] ? sb[i] : sa[i];
      ev(8'(16 + w), 1'h1, pcI, lb[i] < la[i] ? lb[i] : la[i], 1'h0);
      srcRequest <= '0;
    end
    rl = '{20, 30, 31, 20};
    rp = '{32'h00140010, 32'h00100010, 32'h001F0010, 32'h001F0000};
    for (i = 0; i < 4; i++) begin
      lvl(5, rl[i]);
      wr(8'h00, rp[i]);
      srcRequest <= 48'h20;
      inst(0, 8'h00);
      chk("refused", {31'h0, sawLoad} | wa.size(), 32'h0);
      srcRequest <= '0;
    end
    mPsw = 32'h001F0000;
    wr(8'h00, mPsw);
    userNmi <= 1'h1;
    inst(0, 8'h00);
    ev(8'h0F, 1'h1, pcI, 15, 1'h0);
    userNmi <= 1'h0;
    mPsw = 32'h001F0010;
    wr(8'h00, mPsw);
    delayedIrq <= 1'h1;
    inst(0, 8'h00);
    ev(8'h3F, 1'h1, pcI, -1, 1'h0);
    delayedIrq <= 1'h0;
    $display("interrupts done");
    final_report();
  end
endmodule
bind cevu_top cevu_checker i_chk (.clk, .arst_n, .instValid, .isBranch, .branchTaken,
  .branchTarget, .regAddr, .regWr, .memReq, .memWrite, .memAddr, .instAccept, .flushNext,
  .pcLoad, .pcValue, .programStatusWord, .tableBaseRegister);
`default_nettype wire
